// file: design/twe_pkg.sv
// Constants and types shared by the three-wire EEPROM core and its link front end
package twe_pkg;
  // Instruction framing
  localparam int OP_W = 2;
  localparam int ADDR_W_BYTE = 9;
  localparam int ADDR_W_WORD = 8;
  localparam int DATA_W_BYTE = 8;
  localparam int DATA_W_WORD = 16;
  localparam int CNT_W = 5;
  localparam int WORDS = 256;
  localparam logic [1:0] OP_SPECIAL = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] SUB_DISABLE = 2'h0;
  localparam logic [1:0] SUB_FILL = 2'h1;
  localparam logic [1:0] SUB_ERASE_ALL = 2'h2;
  localparam logic [1:0] SUB_ENABLE = 2'h3;
  // Bit index of the last address and data bit, counted after the start bit
  localparam logic [4:0] ADDR_LAST_BYTE = 5'(OP_W + ADDR_W_BYTE - 1);
  localparam logic [4:0] ADDR_LAST_WORD = 5'(OP_W + ADDR_W_WORD - 1);
  localparam logic [4:0] DATA_LAST_BYTE = 5'(OP_W + ADDR_W_BYTE + DATA_W_BYTE - 1);
  localparam logic [4:0] DATA_LAST_WORD = 5'(OP_W + ADDR_W_WORD + DATA_W_WORD - 1);
  localparam logic [3:0] BIT_TOP_BYTE = 4'(DATA_W_BYTE - 1);
  localparam logic [3:0] BIT_TOP_WORD = 4'(DATA_W_WORD - 1);
  // Array contents after reset and after erase
  localparam logic [15:0] MEM_ERASED = 16'hFFFF;
  // Timing
  localparam int SYS_PERIOD_NS = 40;
  localparam int SYS_CLK_KHZ = 1000000 / SYS_PERIOD_NS;
  localparam int TWP_HI_MS = 5;
  localparam int TWP_LO_MS = 10;
  localparam int TWP_HI_CYC = TWP_HI_MS * SYS_CLK_KHZ;
  localparam int TWP_LO_CYC = TWP_LO_MS * SYS_CLK_KHZ;
  localparam int TMR_W = 18;
  localparam int FLOAT_NS = 100;
  localparam int FLOAT_CYC = FLOAT_NS / SYS_PERIOD_NS;
  localparam int STATUS_NS = 200;
  localparam int STATUS_CYC = STATUS_NS / SYS_PERIOD_NS;
  typedef enum logic [1:0] {
    KIND_WRITE = 2'h0,
    KIND_FILL = 2'h1,
    KIND_ERASE = 2'h2,
    KIND_ERASE_ALL = 2'h3
  } twe_kind_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_PROG = 2'h2
  } twe_prog_state_t;
endpackage

// file: design/twe_link.sv
// Serial-clock front end: instruction shifter, decoder and read-out shifter
`timescale 1ns/10ps
module twe_link (
  // Link clock and reset
  input wire logic serial_clock_in_i,
  input wire logic arst_n_i,
  // Pins
  input wire logic chip_select_i,
  input wire logic din_i,
  input wire logic organization_select_i,
  // Array read port
  input wire logic [15:0] rd_word_i,
  output logic [8:0] rd_addr_o,
  output logic dout_o,
  output logic rd_oe_o,
  // Decoded instruction toward the core
  output logic started_o,
  output logic en_o,
  output logic pend_o,
  output logic pend_tog_o,
  output twe_pkg::twe_kind_t kind_o,
  output logic [8:0] addr_o,
  output logic [15:0] data_o
);
  logic link_rst_n;
  logic org_meta_reg, org_reg;
  logic started_reg, done_reg;
  logic [4:0] cnt_reg;
  logic [14:0] sh_reg;
  logic [1:0] op_reg;
  logic [3:0] rd_idx_reg;
  logic [4:0] a_last, d_last;
  logic [3:0] bit_top;
  logic [8:0] a9, addr_now;
  logic [1:0] sub_now;
  logic [15:0] dat_now;
  logic addr_hit, data_hit, is_read, is_wen, is_wds, fin_nodata;

  // Frame logic is held cleared while deselected
  assign link_rst_n = arst_n_i & chip_select_i;

  always_ff @(posedge serial_clock_in_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      org_meta_reg <= 1'b0;
      org_reg <= 1'b0;
    end else begin
      org_meta_reg <= organization_select_i;
      org_reg <= org_meta_reg;
    end
  end

  // Field lengths follow the organization strap
  assign a_last = org_reg ? twe_pkg::ADDR_LAST_WORD : twe_pkg::ADDR_LAST_BYTE;
  assign d_last = org_reg ? twe_pkg::DATA_LAST_WORD : twe_pkg::DATA_LAST_BYTE;
  assign bit_top = org_reg ? twe_pkg::BIT_TOP_WORD : twe_pkg::BIT_TOP_BYTE;
  assign a9 = {sh_reg[7:0], din_i};
  assign addr_now = org_reg ? {1'b0, a9[7:0]} : a9;
  assign sub_now = org_reg ? a9[7:6] : a9[8:7];
  assign dat_now = org_reg ? {sh_reg, din_i} : {8'h00, sh_reg[6:0], din_i};
  assign addr_hit = started_reg && !done_reg && (cnt_reg == a_last);
  assign data_hit = started_reg && !done_reg && (cnt_reg == d_last);
  assign is_read = addr_hit && (op_reg == twe_pkg::OP_READ);
  assign is_wen = addr_hit && (op_reg == twe_pkg::OP_SPECIAL) &&
    (sub_now == twe_pkg::SUB_ENABLE);
  assign is_wds = addr_hit && (op_reg == twe_pkg::OP_SPECIAL) &&
    (sub_now == twe_pkg::SUB_DISABLE);
  // Erase and erase-all end at the address field
  assign fin_nodata = addr_hit && ((op_reg == twe_pkg::OP_ERASE) ||
    ((op_reg == twe_pkg::OP_SPECIAL) && (sub_now == twe_pkg::SUB_ERASE_ALL)));

  // Instruction shifter and read-out
  always_ff @(posedge serial_clock_in_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      started_reg <= 1'b0;
      done_reg <= 1'b0;
      cnt_reg <= 5'h00;
      sh_reg <= 15'h0000;
      op_reg <= 2'h0;
      rd_oe_o <= 1'b0;
      dout_o <= 1'b0;
      rd_addr_o <= 9'h000;
      rd_idx_reg <= 4'h0;
    end else begin
      if (!started_reg) begin
        started_reg <= din_i;
      end else begin
        sh_reg <= {sh_reg[13:0], din_i};
        if (!done_reg) begin
          cnt_reg <= cnt_reg + 5'h01;
        end
        if (!done_reg && (cnt_reg == 5'h01)) begin
          op_reg <= {sh_reg[0], din_i};
        end
        if (addr_hit && !(op_reg == twe_pkg::OP_WRITE) &&
            !((op_reg == twe_pkg::OP_SPECIAL) && (sub_now == twe_pkg::SUB_FILL))) begin
          done_reg <= 1'b1;
        end
        if (data_hit) begin
          done_reg <= 1'b1;
        end
      end
      if (is_read) begin
        rd_oe_o <= 1'b1;
        dout_o <= 1'b0;
        rd_addr_o <= addr_now;
        rd_idx_reg <= bit_top;
      end else if (rd_oe_o) begin
        dout_o <= rd_word_i[rd_idx_reg];
        if (rd_idx_reg == 4'h0) begin
          rd_idx_reg <= bit_top;
          rd_addr_o <= org_reg ? {1'b0, rd_addr_o[7:0] + 8'h01} : rd_addr_o + 9'h001;
        end else begin
          rd_idx_reg <= rd_idx_reg - 4'h1;
        end
      end
    end
  end

  // Decoded state that must outlive the frame
  always_ff @(posedge serial_clock_in_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      en_o <= 1'b0;
      pend_o <= 1'b0;
      pend_tog_o <= 1'b0;
      kind_o <= twe_pkg::KIND_WRITE;
      addr_o <= 9'h000;
      data_o <= 16'h0000;
    end else if (chip_select_i) begin
      if (!started_reg && din_i) begin
        pend_o <= 1'b0;
      end else if (started_reg && done_reg) begin
        pend_o <= 1'b0;
      end else if (fin_nodata || data_hit) begin
        pend_o <= 1'b1;
        pend_tog_o <= ~pend_tog_o;
      end
      if (addr_hit) begin
        addr_o <= addr_now;
        if (op_reg == twe_pkg::OP_WRITE) begin
          kind_o <= twe_pkg::KIND_WRITE;
        end else if (op_reg == twe_pkg::OP_ERASE) begin
          kind_o <= twe_pkg::KIND_ERASE;
        end else if (sub_now == twe_pkg::SUB_FILL) begin
          kind_o <= twe_pkg::KIND_FILL;
        end else begin
          kind_o <= twe_pkg::KIND_ERASE_ALL;
        end
      end
      if (data_hit) begin
        data_o <= dat_now;
      end
      if (is_wen) begin
        en_o <= 1'b1;
      end else if (is_wds) begin
        en_o <= 1'b0;
      end
    end
  end

  assign started_o = started_reg;

  sequence s_read_decoded;
    is_read;
  endsequence
  AST_LEAD_ZERO: assert property (@(posedge serial_clock_in_i) disable iff (!link_rst_n)
    s_read_decoded |=> rd_oe_o && !dout_o)
    else $error("read did not open with a zero bit");
  AST_ENABLE_SETS: assert property (@(posedge serial_clock_in_i) disable iff (!link_rst_n)
    is_wen |=> en_o)
    else $error("enable instruction did not set the latch");
  AST_DISABLE_CLEARS: assert property (@(posedge serial_clock_in_i) disable iff (!link_rst_n)
    is_wds |=> !en_o)
    else $error("disable instruction did not clear the latch");
  AST_SURPLUS_DROPS: assert property (@(posedge serial_clock_in_i) disable iff (!link_rst_n)
    started_reg && done_reg |=> !pend_o)
    else $error("surplus bit left a programming instruction pending");
endmodule

// file: design/twe_core.sv
// Three-wire EEPROM core: array, self-timed programming, status and pin drive
`timescale 1ns/10ps
// Function
// - Read: start 1, opcode 10, full address; contents then shift out.
// - Opcode 00 with address led by 11 sets the programming-permitted latch.
// - Write: start 1, opcode 01, full address, then one data word.
// - Opcode 00 with address led by 01 plus data programs every location.
// - Opcode 00 with address led by 00 clears the programming-permitted latch.
// - Erase: start 1, opcode 11, full address, no data.
// - Opcode 00 with address led by 10 erases the whole array.
// - Organization strap low gives 8-bit words, 9 address bits; high 16 and 8.
// - Wrong bit count drops write, fill, erase and erase-all instructions.
// - Surplus bits are ignored; read, enable and disable still execute.
// - Programming lasts 10 ms on low supply, otherwise 5 ms.
// - Data out floats within 100 ns whenever chip select is low.
// - Reselect during programming shows status within 200 ns.
// - Bits sampled on rising serial clock; instruction starts at first one.
// - Read sends one zero bit then the data, changing on rising clock.
// - Chip select fall after complete instruction programs only when latch set.
// - Status reads zero while programming and one when ready.
module twe_core #(
  parameter int TWP_HI_CYC = twe_pkg::TWP_HI_CYC,
  parameter int TWP_LO_CYC = twe_pkg::TWP_LO_CYC
) (
  // System clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // Serial link
  input wire logic serial_clock_in_i,
  input wire logic chip_select_i,
  input wire logic din_i,
  output logic dout_o,
  output logic dout_oe_o,
  // Straps
  input wire logic organization_select_i,
  input wire logic low_supply_i
);
  localparam int FLOAT_WIN = twe_pkg::FLOAT_CYC;

  // Link side
  logic [15:0] rd_word;
  logic [8:0] link_rd_addr;
  logic link_dout, link_rd_oe;
  logic link_started, link_en, link_pend, link_tog;
  twe_pkg::twe_kind_t link_kind;
  logic [8:0] link_addr;
  logic [15:0] link_data;

  // Synchronisers
  logic cs_meta_reg, cs_reg, cs_d_reg;
  logic org_meta_reg, org_reg;
  logic low_meta_reg, low_reg;
  logic st_meta_reg, st_reg;
  logic tog_meta_reg, tog_reg, tog_seen_reg;

  // Programming
  twe_pkg::twe_prog_state_t state_reg;
  logic [twe_pkg::TMR_W-1:0] tmr_reg;
  twe_pkg::twe_kind_t kind_reg;
  logic [8:0] addr_reg;
  logic [15:0] data_reg;
  logic org_q_reg;
  logic cs_fall, start_prog, commit;
  logic erase_kind, all_kind, lane_lo, lane_hi;
  logic [15:0] wr_val;
  logic [15:0] mem_q [twe_pkg::WORDS];

  // Status
  logic armed_reg, stat_oe_reg, stat_bit_reg;

  twe_link u_link (
    .serial_clock_in_i(serial_clock_in_i),
    .arst_n_i(arst_n_i),
    .chip_select_i(chip_select_i),
    .din_i(din_i),
    .organization_select_i(organization_select_i),
    .rd_word_i(rd_word),
    .rd_addr_o(link_rd_addr),
    .dout_o(link_dout),
    .rd_oe_o(link_rd_oe),
    .started_o(link_started),
    .en_o(link_en),
    .pend_o(link_pend),
    .pend_tog_o(link_tog),
    .kind_o(link_kind),
    .addr_o(link_addr),
    .data_o(link_data)
  );

  // Pin and link levels into the system domain
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cs_meta_reg <= 1'b0;
      cs_reg <= 1'b0;
      cs_d_reg <= 1'b0;
      org_meta_reg <= 1'b0;
      org_reg <= 1'b0;
      low_meta_reg <= 1'b0;
      low_reg <= 1'b0;
      st_meta_reg <= 1'b0;
      st_reg <= 1'b0;
      tog_meta_reg <= 1'b0;
      tog_reg <= 1'b0;
    end else begin
      cs_meta_reg <= chip_select_i;
      cs_reg <= cs_meta_reg;
      cs_d_reg <= cs_reg;
      org_meta_reg <= organization_select_i;
      org_reg <= org_meta_reg;
      low_meta_reg <= low_supply_i;
      low_reg <= low_meta_reg;
      st_meta_reg <= link_started;
      st_reg <= st_meta_reg;
      tog_meta_reg <= link_tog;
      tog_reg <= tog_meta_reg;
    end
  end

  // Fields stay frozen while deselected, so they are read directly after the fall
  assign cs_fall = cs_d_reg && !cs_reg;
  assign start_prog = cs_fall && link_pend && link_en && (tog_reg != tog_seen_reg) &&
    (state_reg == twe_pkg::ST_IDLE);
  assign commit = (state_reg == twe_pkg::ST_PROG) && (tmr_reg == '0);

  // New-instruction tracking, one launch per decoded instruction
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tog_seen_reg <= 1'b0;
    end else if (cs_fall) begin
      tog_seen_reg <= tog_reg;
    end
  end

  // Self-timed programming sequencer
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= twe_pkg::ST_IDLE;
      tmr_reg <= '0;
    end else begin
      case (state_reg)
        twe_pkg::ST_IDLE: begin
          if (start_prog) begin
            state_reg <= twe_pkg::ST_PROG;
            tmr_reg <= low_reg ? twe_pkg::TMR_W'(TWP_LO_CYC - 1) :
              twe_pkg::TMR_W'(TWP_HI_CYC - 1);
          end
        end
        twe_pkg::ST_PROG: begin
          if (commit) begin
            state_reg <= twe_pkg::ST_IDLE;
          end else begin
            tmr_reg <= tmr_reg - twe_pkg::TMR_W'(1);
          end
        end
        default: begin
          state_reg <= twe_pkg::ST_IDLE;
          tmr_reg <= '0;
        end
      endcase
    end
  end

  // Instruction captured at launch
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      kind_reg <= twe_pkg::KIND_WRITE;
      addr_reg <= 9'h000;
      data_reg <= 16'h0000;
      org_q_reg <= 1'b0;
    end else if (start_prog) begin
      kind_reg <= link_kind;
      addr_reg <= link_addr;
      data_reg <= link_data;
      org_q_reg <= org_reg;
    end
  end

  // Value and byte lanes written at the end of the cycle
  assign erase_kind = (kind_reg == twe_pkg::KIND_ERASE) || (kind_reg == twe_pkg::KIND_ERASE_ALL);
  assign all_kind = (kind_reg == twe_pkg::KIND_FILL) || (kind_reg == twe_pkg::KIND_ERASE_ALL);
  assign wr_val = erase_kind ? twe_pkg::MEM_ERASED :
    (org_q_reg ? data_reg : {data_reg[7:0], data_reg[7:0]});
  assign lane_lo = org_q_reg || all_kind || !addr_reg[0];
  assign lane_hi = org_q_reg || all_kind || addr_reg[0];

  // Array, one word per entry
  for (genvar i = 0; i < twe_pkg::WORDS; i++) begin : g_word
    logic sel;
    logic [15:0] word_reg;
    assign sel = all_kind || (org_q_reg ? (addr_reg[7:0] == 8'(i)) :
      (addr_reg[8:1] == 8'(i)));
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        word_reg <= twe_pkg::MEM_ERASED;
      end else if (commit && sel) begin
        word_reg <= {lane_hi ? wr_val[15:8] : word_reg[15:8],
          lane_lo ? wr_val[7:0] : word_reg[7:0]};
      end
    end
    assign mem_q[i] = word_reg;
  end

  // Read port; contents only change while busy, when the host may not read
  always_comb begin
    rd_word = 16'h0000;
    if (org_reg) begin
      rd_word = mem_q[link_rd_addr[7:0]];
    end else if (link_rd_addr[0]) begin
      rd_word = {8'h00, mem_q[link_rd_addr[8:1]][15:8]};
    end else begin
      rd_word = {8'h00, mem_q[link_rd_addr[8:1]][7:0]};
    end
  end

  // Ready/busy status shown on reselect until a start bit clears it
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      armed_reg <= 1'b0;
      stat_oe_reg <= 1'b0;
      stat_bit_reg <= 1'b1;
    end else begin
      if (start_prog) begin
        armed_reg <= 1'b1;
      end else if (st_reg || (!cs_reg && (state_reg == twe_pkg::ST_IDLE))) begin
        armed_reg <= 1'b0;
      end
      stat_oe_reg <= cs_reg && armed_reg && !st_reg;
      stat_bit_reg <= (state_reg == twe_pkg::ST_IDLE);
    end
  end

  // Pin drive: read data from the link flop, status from the core flop
  assign dout_oe_o = link_rd_oe || (stat_oe_reg && cs_reg);
  assign dout_o = link_rd_oe ? link_dout : stat_bit_reg;

  // Checks
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  logic [twe_pkg::TMR_W:0] ast_len_reg;
  logic [twe_pkg::TMR_W:0] ast_lim_reg;
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ast_len_reg <= '0;
      ast_lim_reg <= '0;
    end else if (start_prog) begin
      ast_len_reg <= '0;
      ast_lim_reg <= low_reg ? (twe_pkg::TMR_W + 1)'(TWP_LO_CYC) :
        (twe_pkg::TMR_W + 1)'(TWP_HI_CYC);
    end else if (state_reg == twe_pkg::ST_PROG) begin
      ast_len_reg <= ast_len_reg + 1'b1;
    end
  end

  sequence s_deselect;
    $fell(cs_reg);
  endsequence
  sequence s_reselect_armed;
    $rose(cs_reg) && armed_reg && !st_reg ##1 (cs_reg && !st_reg);
  endsequence

  AST_FLOAT_ON_DESELECT: assert property (s_deselect |-> ##[0:FLOAT_WIN] !dout_oe_o)
    else $error("data out still driven after deselect");
  AST_PROG_NEEDS_LATCH: assert property ($rose(state_reg == twe_pkg::ST_PROG) |->
    $past(link_en) && $past(cs_fall))
    else $error("programming began without latch or deselect");
  AST_PROG_LENGTH: assert property ($fell(state_reg == twe_pkg::ST_PROG) |->
    ast_len_reg == ast_lim_reg)
    else $error("programming cycle length wrong");
  AST_BUSY_READS_ZERO: assert property ((state_reg == twe_pkg::ST_PROG)[*2] |->
    !stat_bit_reg)
    else $error("status not zero while programming");
  AST_READY_READS_ONE: assert property ((state_reg == twe_pkg::ST_IDLE)[*2] |->
    stat_bit_reg)
    else $error("status not one while ready");
  AST_STATUS_SHOWN: assert property (s_reselect_armed |-> dout_oe_o)
    else $error("status not driven after reselect");
  AST_ERASE_ALL_ONES: assert property (commit && (kind_reg == twe_pkg::KIND_ERASE_ALL) |=>
    (mem_q[0] == twe_pkg::MEM_ERASED) && (mem_q[twe_pkg::WORDS-1] == twe_pkg::MEM_ERASED))
    else $error("erase-all left a zero bit");
  AST_FILL_ALL: assert property (commit && (kind_reg == twe_pkg::KIND_FILL) && org_q_reg |=>
    (mem_q[0] == data_reg) && (mem_q[twe_pkg::WORDS-1] == data_reg))
    else $error("fill did not reach every word");
endmodule

// file: dv/twe_host.sv
// Host-side serial master model that drives the link pins
`timescale 1ns/10ps
module twe_host (
  // Link pins
  output logic sclk_o,
  output logic cs_o,
  output logic din_o,
  input wire logic dout_i
);
  logic [31:0] rx;
  initial begin
    sclk_o = 1'b0;
    cs_o = 1'b0;
    din_o = 1'b0;
    rx = 32'h0;
  end
  // Bits MSB first, one per 15 ns period; clock stands still outside frames except for the two stray pulses of drop()
  task automatic shift(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      din_o = v[i];
      #7.5;
      rx = {rx[30:0], dout_i};
      sclk_o = 1'b1;
      #7.5;
      sclk_o = 1'b0;
    end
  endtask
  task automatic sel();
    cs_o = 1'b1;
    #50;
  endtask
  // Deselect, with stray clock edges that must be ignored
  task automatic drop();
    cs_o = 1'b0;
    din_o = 1'b1;
    repeat (2) begin
      #7.5 sclk_o = 1'b1;
      #7.5 sclk_o = 1'b0;
    end
    #70;
  endtask
endmodule

// file: dv/tb.sv
// Self-checking testbench for the three-wire EEPROM core
`timescale 1ns/10ps
module tb;
  logic sys_clk_i;
  logic arst_n_i;
  logic organization_select;
  logic low;
  logic sclk;
  logic cs;
  logic din;
  logic dout_o;
  logic dout_oe_o;
  wire dout_w;
  int fails;
  int checks;
  assign dout_w = dout_oe_o ? dout_o : 1'bz;
  twe_core #(.TWP_HI_CYC(200), .TWP_LO_CYC(400)) dut (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .serial_clock_in_i(sclk),
    .chip_select_i(cs), .din_i(din), .dout_o(dout_o), .dout_oe_o(dout_oe_o),
    .organization_select_i(organization_select), .low_supply_i(low));
  twe_host host (.sclk_o(sclk), .cs_o(cs), .din_o(din), .dout_i(dout_w));
  initial sys_clk_i = 1'b0;
  always #20 sys_clk_i = ~sys_clk_i;
  task automatic test_done();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic strap(input logic o, input logic l);
    @(negedge sys_clk_i);
    organization_select = o;
    low = l;
  endtask
  task automatic deselect();
    host.drop();
    cmp(dout_oe_o, 1'b0);
    #200;
  endtask
  // Read two consecutive words in word organization
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e0, input logic [15:0] e1);
    host.sel();
    host.shift({21'h0, 3'b110, a}, 11);
    host.shift(32'h0, 17);
    cmp(host.rx[16:0], {1'b0, e0});
    host.shift(32'h0, 16);
    cmp(host.rx[15:0], e1);
    deselect();
  endtask
  // One instruction; twp 0 means no programming may start
  task automatic prog(input logic [31:0] v, input int n, input int twp);
    int k;
    k = 0;
    host.sel();
    host.shift(v, n);
    deselect();
    host.sel();
    repeat (4) @(negedge sys_clk_i);
    if (twp == 0) begin
      cmp(dout_oe_o, 1'b0);
    end else begin
      cmp(dout_w, 1'b0);
      while (dout_w !== 1'b1 && k < 1000) begin
        @(negedge sys_clk_i);
        k++;
      end
      if (k == 1000) begin
        fails++;
        test_done();
      end
      cmp(k >= twp - 20 && k <= twp, 1);
    end
    deselect();
  endtask
  task automatic t_protect();
    cmp(dout_oe_o, 1'b0);
    rd_chk(8'h05, 16'hFFFF, 16'hFFFF);
    prog({5'h0, 3'b101, 8'h05, 16'h1234}, 27, 0);
    $display("test protect done");
  endtask
  task automatic t_write();
    prog({21'h0, 3'b100, 8'hC0}, 11, 0);
    prog({5'h0, 3'b101, 8'h05, 16'h1234}, 27, 200);
    prog({4'h0, 3'b101, 8'h06, 16'hABCD, 1'b0}, 28, 0);
    rd_chk(8'h05, 16'h1234, 16'hFFFF);
    $display("test write done");
  endtask
  task automatic t_mismatch();
    prog({20'h0, 3'b100, 8'h00, 1'b1}, 12, 0);
    prog({5'h0, 3'b101, 8'h06, 16'hABCD}, 27, 0);
    rd_chk(8'h06, 16'hFFFF, 16'hFFFF);
    prog({20'h0, 3'b100, 8'hC0, 1'b0}, 12, 0);
    $display("test mismatch done");
  endtask
  task automatic t_erase();
    strap(1'b1, 1'b1);
    prog({21'h0, 3'b111, 8'h05}, 11, 400);
    rd_chk(8'h05, 16'hFFFF, 16'hFFFF);
    strap(1'b1, 1'b0);
    $display("test erase done");
  endtask
  task automatic t_fill_wrap();
    prog({5'h0, 3'b100, 8'h40, 16'h5A5A}, 27, 200);
    prog({5'h0, 3'b101, 8'h00, 16'h0F0F}, 27, 200);
    rd_chk(8'hFF, 16'h5A5A, 16'h0F0F);
    prog({21'h0, 3'b100, 8'h80}, 11, 200);
    rd_chk(8'h10, 16'hFFFF, 16'hFFFF);
    $display("test fill done");
  endtask
  task automatic t_byte();
    strap(1'b0, 1'b0);
    prog({12'h0, 3'b101, 9'h001, 8'h3C}, 20, 200);
    strap(1'b1, 1'b0);
    rd_chk(8'h00, 16'h3CFF, 16'hFFFF);
    $display("test byte done");
  endtask
  initial begin
    fails = 0;
    checks = 0;
    organization_select = 1'b1;
    low = 1'b0;
    arst_n_i = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    arst_n_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    t_protect();
    t_write();
    t_mismatch();
    t_erase();
    t_fill_wrap();
    t_byte();
    test_done();
  end
endmodule
